// ### opa_acquisition.sv
// Purpose: Presence detection, LED pulse timing, sample capture and buffer
// Assumes: Converter handshake arrives from another clock domain
// Notes:   One Avalon-MM slave, one open-drain interrupt pin
`timescale 1ns/1ps
`default_nettype none
module opa_acquisition
  import opa_pkg::*;
(
  input  wire logic        sys_clk,          // System clock, 250 MHz
  input  wire logic        rst_n,            // Synchronous reset, active low
  input  wire logic [7:0]  avs_address,      // Byte address
  input  wire logic        avs_read,         // Read request
  input  wire logic        avs_write,        // Write request
  input  wire logic [31:0] avs_writedata,    // Write data
  output logic      [31:0] avs_readdata,     // Read data
  output logic             avs_waitrequest,  // Stall request
  input  wire logic        adc_valid,        // Conversion done, async level
  input  wire logic [18:0] adc_count,        // Converter result
  output opa_led_type      led_drive,        // LED pulse and current
  output logic             adc_start,        // Start of conversion
  output logic             interrupt_out,    // Open-drain output level, 0
  output logic             interrupt_oe      // Drives pin low when high
);

  // Pulse width lookup, used by the pulse timer
  function automatic logic [16:0] pw_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0:    pw_cycles = PW_CYC_0;
      2'h1:    pw_cycles = PW_CYC_1;
      2'h2:    pw_cycles = PW_CYC_2;
      default: pw_cycles = PW_CYC_3;
    endcase
  endfunction

  // Sample period lookup in cycles
  function automatic logic [24:0] period_cycles(input logic [2:0] sel);
    unique case (sel)
      3'h0:    period_cycles = 25'(CLK_HZ / SPS_0);
      3'h1:    period_cycles = 25'(CLK_HZ / SPS_1);
      3'h2:    period_cycles = 25'(CLK_HZ / SPS_2);
      3'h3:    period_cycles = 25'(CLK_HZ / SPS_3);
      3'h4:    period_cycles = 25'(CLK_HZ / SPS_4);
      3'h5:    period_cycles = 25'(CLK_HZ / SPS_5);
      3'h6:    period_cycles = 25'(CLK_HZ / SPS_6);
      default: period_cycles = 25'(CLK_HZ / SPS_7);
    endcase
  endfunction

  // Clamp a current code to the 100 mA ceiling
  function automatic logic [7:0] clamp_cur(input logic [7:0] code);
    clamp_cur = (code > CURRENT_MAX_CODE) ? CURRENT_MAX_CODE : code;
  endfunction

  // Software registers
  logic [INT_BITS-1:0]    int_status;        // Sticky flags
  logic [INT_BITS-1:0]    int_enable;        // Mask, bit 1 enables presence
  logic [1:0]             meas_sel;          // Measurement selection
  logic [31:0]            led_cfg;           // Current and width fields
  logic [2:0]             rate_sel;          // Sample rate code
  logic [7:0]             thresh;            // Presence threshold
  opa_state_type          state;             // Acquisition state

  // Converter handshake synchroniser and edge
  logic                   valid_meta;        // First stage, read by sync only
  logic                   valid_sync;        // Second stage
  logic                   valid_prev;        // For edge detection
  logic [18:0]            count_hold;        // Sampled with the edge

  // Timing counters
  logic [24:0]            period_cnt;        // Sample period countdown
  logic [16:0]            pulse_cnt;         // LED on-time countdown
  logic                   red_phase;         // Alternates LEDs in SpO2

  // Sample buffer
  logic [SAMPLE_BITS-1:0] fifo_mem [FIFO_DEPTH]; // Sample store
  logic [PTR_BITS-1:0]    wr_ptr;            // Next write slot
  logic [PTR_BITS-1:0]    rd_ptr;            // Next read slot
  logic [PTR_BITS:0]      level;             // Samples held

  // Bus decode: one-cycle waitrequest gives a registered answer
  logic bus_req;
  logic bus_ack;
  logic wr_status, wr_enable, wr_control, wr_led, wr_rate, wr_thresh;
  logic rd_pop;
  assign bus_req    = avs_read | avs_write;
  assign bus_ack    = bus_req & ~avs_waitrequest;
  assign wr_status  = bus_ack & avs_write & (avs_address == OFS_INT_STATUS);
  assign wr_enable  = bus_ack & avs_write & (avs_address == OFS_INT_ENABLE);
  assign wr_control = bus_ack & avs_write & (avs_address == OFS_CONTROL);
  assign wr_led     = bus_ack & avs_write & (avs_address == OFS_LED_CFG);
  assign wr_rate    = bus_ack & avs_write & (avs_address == OFS_RATE_CFG);
  assign wr_thresh  = bus_ack & avs_write & (avs_address == OFS_THRESH);
  assign rd_pop     = bus_ack & avs_read & (avs_address == OFS_FIFO_DATA)
                      & (level != '0);

  // Presence enable and sample events
  logic presence_en;
  logic valid_edge;         // Rising edge of the synced valid level
  logic sample_evt;         // Edge one cycle late, count_hold now fresh
  logic detected;
  logic fifo_full;
  logic push;
  logic pulse_start;
  assign presence_en = int_enable[BIT_PRESENCE];
  assign valid_edge  = valid_sync & ~valid_prev;
  assign detected    = sample_evt & (state == ST_PRESENCE)
                       & (count_hold > {11'h000, thresh});
  assign fifo_full   = (level == 6'(FIFO_DEPTH));
  assign push        = sample_evt & (state == ST_NORMAL) & ~fifo_full;
  assign pulse_start = (state != ST_IDLE) & (period_cnt == '0);

  // Next acquisition state
  opa_state_type next_state;
  always_comb
  begin
    next_state = state;
    if (wr_control)
    begin
      if (avs_writedata[1:0] == MEAS_OFF)
        next_state = ST_IDLE;
      else if (presence_en)
        next_state = ST_PRESENCE;
      else
        next_state = ST_NORMAL;
    end
    else if (detected)
      next_state = ST_NORMAL;
  end

  // Next LED drive; presence mode uses pilot current on infrared only
  opa_led_type next_led;
  logic        pulse_on;
  assign pulse_on = (pulse_cnt != '0);
  always_comb
  begin
    next_led = '0;
    if (state == ST_PRESENCE)
    begin
      next_led.ir_on      = pulse_on;
      next_led.ir_current =
        clamp_cur(led_cfg[LED_PILOT_LSB +: 8]);
    end
    else if (state == ST_NORMAL)
    begin
      next_led.red_on      = pulse_on & red_phase;
      next_led.ir_on       = pulse_on & ~red_phase;
      next_led.red_current = clamp_cur(led_cfg[LED_RED_LSB +: 8]);
      next_led.ir_current  = clamp_cur(led_cfg[LED_IR_LSB +: 8]);
    end
  end

  // Read data mux
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (avs_address)
      OFS_INT_STATUS: next_rdata = {29'h0, int_status};
      OFS_INT_ENABLE: next_rdata = {29'h0, int_enable};
      OFS_CONTROL:    next_rdata = {28'h0, state, meas_sel};
      OFS_LED_CFG:    next_rdata = led_cfg;
      OFS_RATE_CFG:   next_rdata = {29'h0, rate_sel};
      OFS_THRESH:     next_rdata = {24'h0, thresh};
      OFS_FIFO_DATA:  next_rdata = {13'h0, fifo_mem[rd_ptr]};
      OFS_FIFO_STAT:  next_rdata = {26'h0, level};
      default:        next_rdata = 32'h0000_0000;               // Unmapped
    endcase
  end

  // Status flags: hardware set wins over write-one clear
  logic [INT_BITS-1:0] set_bits;
  logic [INT_BITS-1:0] clr_bits;
  assign set_bits = {sample_evt & (state == ST_NORMAL) & fifo_full,
                     detected, push};
  assign clr_bits = wr_status ? avs_writedata[INT_BITS-1:0] : '0;

  // Bus handshake: wait one cycle, then answer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (bus_req & avs_waitrequest)
      avs_readdata <= next_rdata;
  end

  // Configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      int_enable <= '0;
      meas_sel   <= MEAS_OFF;
      led_cfg    <= LED_CFG_RST;
      rate_sel   <= 3'h0;
      thresh     <= THRESH_RST;
    end
    else
    begin
      if (wr_enable)  int_enable <= avs_writedata[INT_BITS-1:0];
      if (wr_control) meas_sel   <= avs_writedata[1:0];
      if (wr_led)     led_cfg    <= avs_writedata;
      if (wr_rate)    rate_sel   <= avs_writedata[2:0];
      if (wr_thresh)  thresh     <= avs_writedata[7:0];
    end
  end

  // Flags and state
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      int_status <= '0;
      state      <= ST_IDLE;
    end
    else
    begin
      int_status <= (int_status & ~clr_bits) | set_bits;
      state      <= next_state;
    end
  end

  // Converter handshake crossing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      valid_meta <= 1'b0;
      valid_sync <= 1'b0;
      valid_prev <= 1'b0;
      sample_evt <= 1'b0;
      count_hold <= '0;
    end
    else
    begin
      valid_meta <= adc_valid;
      valid_sync <= valid_meta;
      valid_prev <= valid_sync;
      // Event lags the capture so detection and push see the new count
      sample_evt <= valid_edge;
      // Count has been stable a cycle by the synced edge; capture once
      if (valid_edge)
        count_hold <= adc_count;
    end
  end

  // Sample period and LED pulse timer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || state == ST_IDLE)
    begin
      period_cnt <= '0;
      pulse_cnt  <= '0;
      red_phase  <= 1'b0;
      adc_start  <= 1'b0;
    end
    else
    begin
      adc_start <= pulse_start;
      if (pulse_start)
      begin
        period_cnt <= period_cycles(rate_sel) - 25'h1;
        pulse_cnt  <= pw_cycles(led_cfg[LED_PW_LSB +: 2]);
        red_phase  <= (meas_sel == MEAS_SPO2) & ~red_phase;
      end
      else
      begin
        period_cnt <= period_cnt - 25'h1;
        if (pulse_on)
          pulse_cnt <= pulse_cnt - 17'h1;
      end
    end
  end

  // Sample buffer; writes are dropped while full
  always_ff @(posedge sys_clk)
  begin
    if (push)
      fifo_mem[wr_ptr] <= count_hold;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || wr_control)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end
    else
    begin
      if (push)   wr_ptr <= wr_ptr + 5'h1;
      if (rd_pop) rd_ptr <= rd_ptr + 5'h1;
      level <= level + {5'h0, push} - {5'h0, rd_pop};
    end
  end

  // LED outputs and interrupt pin
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      led_drive     <= '0;
      interrupt_out <= 1'b0;
      interrupt_oe  <= 1'b0;
    end
    else
    begin
      led_drive     <= next_led;
      interrupt_out <= 1'b0;
      interrupt_oe  <= |(int_status & int_enable);
    end
  end

endmodule
`default_nettype wire

// ### opa_pkg.sv
// Purpose: Shared constants and types for the optical presence acquisition
// Assumes: 250 MHz system clock, 32-bit Avalon-MM register slave
// Notes:   Byte offsets are word aligned; all registers are one word wide
package opa_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_INT_STATUS = 8'h00; // Sticky event flags
  localparam logic [7:0] OFS_INT_ENABLE = 8'h04; // Interrupt mask
  localparam logic [7:0] OFS_CONTROL    = 8'h08; // Measurement select
  localparam logic [7:0] OFS_LED_CFG    = 8'h0C; // Currents and pulse width
  localparam logic [7:0] OFS_RATE_CFG   = 8'h10; // Sample rate select
  localparam logic [7:0] OFS_THRESH     = 8'h14; // Presence threshold
  localparam logic [7:0] OFS_FIFO_DATA  = 8'h18; // Pops one sample on read
  localparam logic [7:0] OFS_FIFO_STAT  = 8'h1C; // Buffer level

  // Interrupt bit positions
  localparam int BIT_SAMPLE_RDY = 0;            // New sample stored
  localparam int BIT_PRESENCE   = 1;            // Object detected
  localparam int BIT_OVERFLOW   = 2;            // Sample lost, buffer full
  localparam int INT_BITS       = 3;            // Width of flag field

  // Control field: measurement selection
  localparam logic [1:0] MEAS_OFF   = 2'h0;     // No acquisition
  localparam logic [1:0] MEAS_HR    = 2'h1;     // Infrared only
  localparam logic [1:0] MEAS_SPO2  = 2'h2;     // Red and infrared

  // LED config field positions
  localparam int LED_IR_LSB    = 0;             // Infrared current code
  localparam int LED_RED_LSB   = 8;             // Red current code
  localparam int LED_PILOT_LSB = 16;            // Pilot current code
  localparam int LED_PW_LSB    = 24;            // Pulse width select

  // Sizes
  localparam int SAMPLE_BITS = 19;              // Converter resolution
  localparam int FIFO_DEPTH  = 32;              // Buffered samples
  localparam int PTR_BITS    = 5;               // log2 of depth

  // Current: code 0..250 maps 0..100 mA in 0.4 mA steps
  localparam logic [7:0] CURRENT_MAX_CODE = 8'hFA; // Saturation point

  // Pulse widths in microseconds and the derived cycle counts
  localparam int CLK_MHZ = 250;                 // System clock rate
  localparam int PW_US_0 = 50;                  // Shortest pulse
  localparam int PW_US_1 = 100;
  localparam int PW_US_2 = 200;
  localparam int PW_US_3 = 400;                 // Longest pulse
  localparam logic [16:0] PW_CYC_0 = 17'(PW_US_0 * CLK_MHZ);
  localparam logic [16:0] PW_CYC_1 = 17'(PW_US_1 * CLK_MHZ);
  localparam logic [16:0] PW_CYC_2 = 17'(PW_US_2 * CLK_MHZ);
  localparam logic [16:0] PW_CYC_3 = 17'(PW_US_3 * CLK_MHZ);

  // Sample rates in samples per second, 10 to 3200
  localparam int SPS_0 = 10;
  localparam int SPS_1 = 50;
  localparam int SPS_2 = 100;
  localparam int SPS_3 = 200;
  localparam int SPS_4 = 400;
  localparam int SPS_5 = 800;
  localparam int SPS_6 = 1600;
  localparam int SPS_7 = 3200;
  localparam int CLK_HZ = CLK_MHZ * 1000000;    // System clock in hertz

  // Reset values
  localparam logic [31:0] LED_CFG_RST = 32'h0000_0000; // LEDs off
  localparam logic [7:0]  THRESH_RST  = 8'h00;         // Threshold

  // Acquisition states
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,                        // Nothing selected
    ST_PRESENCE = 2'b01,                        // Pilot infrared only
    ST_NORMAL   = 2'b10                         // Full measurement
  } opa_state_type;

  // LED drive bundle toward the analog front end
  typedef struct packed {
    logic       red_on;                         // Red LED pulse
    logic       ir_on;                          // Infrared LED pulse
    logic [7:0] red_current;                    // Red current code
    logic [7:0] ir_current;                     // Infrared current code
  } opa_led_type;

endpackage

// ### opa_acq_asserts.sv
// Purpose: Port-level checks for the optical presence acquisition block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every acquisition block instance
`timescale 1ns/1ps
`default_nettype none
module opa_acq_asserts
  import opa_pkg::*;
(
  input wire logic        sys_clk,         // System clock
  input wire logic        rst_n,           // Sync reset, active low
  input wire logic [7:0]  avs_address,     // Byte address
  input wire logic        avs_read,        // Read request
  input wire logic        avs_write,       // Write request
  input wire logic [31:0] avs_writedata,   // Write data
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic        avs_waitrequest, // Stall request
  input wire logic        adc_valid,       // Converter flag
  input wire logic [18:0] adc_count,       // Converter result
  input wire opa_led_type led_drive,       // LED bundle
  input wire logic        adc_start,       // Conversion start
  input wire logic        interrupt_out,   // Pin level when driven
  input wire logic        interrupt_oe     // Pin pulled low
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  wire logic req    = avs_read | avs_write;        // Any request
  wire logic rd_ack = avs_read & !avs_waitrequest; // Read answered

  // Bus handshake: one answer cycle a request, idle stays stalled
  answer_next_a: assert property
    (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  ack_single_a: assert property
    (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  idle_stall_a: assert property
    (!req |=> avs_waitrequest)
    else $error("answer without a request");
  // Read data may only move in the answer cycle
  read_hold_a: assert property
    (!$stable(avs_readdata) |-> !avs_waitrequest)
    else $error("read data moved outside an answer");
  unmapped_zero_a: assert property
    (rd_ack && avs_address > OFS_FIFO_STAT
    |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  sample_width_a: assert property
    (rd_ack && avs_address == OFS_FIFO_DATA
    |-> avs_readdata[31:19] == 13'h0000)
    else $error("sample wider than converter");
  pin_level_a: assert property
    (interrupt_out == 1'b0)
    else $error("interrupt pin driven high");
  start_pulse_a: assert property
    (adc_start |=> !adc_start)
    else $error("conversion start longer than a cycle");
  start_led_a: assert property
    (adc_start |-> ##[0:1] (led_drive.ir_on || led_drive.red_on))
    else $error("conversion start without LED pulse");
  current_cap_a: assert property
    (led_drive.ir_current <= CURRENT_MAX_CODE
    && led_drive.red_current <= CURRENT_MAX_CODE)
    else $error("LED current above full scale");
  // Own disable: this one looks inside the reset
  reset_state_a: assert property
    (disable iff (1'b0) !rst_n
    |=> avs_waitrequest && !interrupt_oe && !adc_start)
    else $error("outputs not at rest after reset");

  cover property (rd_ack && avs_address == OFS_FIFO_DATA);
  cover property ($rose(interrupt_oe));
  cover property (avs_write && !avs_waitrequest && avs_address == OFS_CONTROL);
endmodule

bind opa_acquisition opa_acq_asserts u_opa_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .adc_valid(adc_valid), .adc_count(adc_count), .led_drive(led_drive),
  .adc_start(adc_start), .interrupt_out(interrupt_out),
  .interrupt_oe(interrupt_oe));
`default_nettype wire

// ### opa_conv_model.sv
// Purpose: Converter model delivering results from its own clock domain
// Assumes: Link clock runs at a 48 ns period, unrelated to the system
// Notes:   Result is garbled once valid drops, so stale reads show up
`timescale 1ns/1ps
`default_nettype none
module opa_conv_model
(
  output logic        adc_valid,  // Result ready, level
  output logic [18:0] adc_count   // Converter result
);
  logic link_clk;                 // Converter's own clock

  // Free-running link clock; phase unrelated to the system clock
  initial
  begin
    link_clk = 1'b0;
    adc_valid = 1'b0;
    adc_count = 19'h2AAAA;
    forever #24 link_clk = ~link_clk;
  end

  // One result, held two link cycles so a two-stage sync catches it
  task automatic send(input logic [18:0] value);
    @(posedge link_clk);
    adc_count <= value;
    adc_valid <= 1'b1;
    repeat (2) @(posedge link_clk);
    adc_valid <= 1'b0;
    adc_count <= ~value;          // Hold time over: no longer valid
    repeat (2) @(posedge link_clk);
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench for the optical presence acquisition block
// Assumes: Avalon-MM master waits on waitrequest, no fixed latency
// Notes:   Converter results come from the model, not from adc_start
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import opa_pkg::*;
;
  logic        sys_clk;          // 250 MHz system clock
  logic        rst_n;            // Sync reset, active low
  logic [7:0]  avs_address;      // Bus address
  logic        avs_read;         // Bus read
  logic        avs_write;        // Bus write
  logic [31:0] avs_writedata;    // Bus write data
  logic [31:0] avs_readdata;     // Bus read data
  logic        avs_waitrequest;  // Bus stall
  logic        adc_valid;        // From converter model
  logic [18:0] adc_count;        // From converter model
  opa_led_type led_drive;        // LED bundle
  logic        adc_start;        // Conversion start
  logic        interrupt_out;    // Pin level
  logic        interrupt_oe;     // Pin pulled low
  int          error_cnt;        // Mismatches
  int          cmp_count;        // Comparisons
  int          cycles;           // Timeout counter
  logic [31:0] rd_val;           // Last read data

  opa_acquisition dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .adc_valid(adc_valid), .adc_count(adc_count), .led_drive(led_drive),
    .adc_start(adc_start), .interrupt_out(interrupt_out),
    .interrupt_oe(interrupt_oe));
  opa_conv_model conv (.adc_valid(adc_valid), .adc_count(adc_count));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Ceiling well above the few thousand cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus access; an idle edge after release avoids double assignment
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd_val & m, e);
  endtask

  // Pin output is registered: let the flag and mask updates land
  task automatic pin_chk(input logic e);
    repeat (3) @(posedge sys_clk);
    check({31'h0, interrupt_oe}, {31'h0, e});
  endtask

  function automatic logic [18:0] smp(input int i);
    return 19'h7FF00 ^ 19'(i * 32'h357);
  endfunction

  initial
  begin
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    error_cnt = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(OFS_INT_STATUS, 32'h7, 32'h0);
    rd_chk(OFS_INT_ENABLE, 32'h7, 32'h0);
    rd_chk(OFS_LED_CFG, 32'h03FF_FFFF, LED_CFG_RST);
    rd_chk(OFS_THRESH, 32'hFF, {24'h0, THRESH_RST});
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0);
    for (int r = 0; r < 8; r++)
    begin
      wr(OFS_RATE_CFG, r);
      rd_chk(OFS_RATE_CFG, 32'h7, r);
    end
    for (int p = 0; p < 4; p++)
    begin
      wr(OFS_LED_CFG, (p << LED_PW_LSB) | 32'h0030_FA10);
      rd_chk(OFS_LED_CFG, 32'h03FF_FFFF, (p << 24) | 32'h0030_FA10);
    end
    wr(OFS_THRESH, 32'h40);
    for (int m = 1; m < 3; m++)
    begin
      wr(OFS_INT_ENABLE, 32'h0);
      wr(OFS_CONTROL, m);
      rd_chk(OFS_CONTROL, 32'hF, 32'h8 | m);
      wr(OFS_INT_ENABLE, 32'h2);
      rd_chk(OFS_CONTROL, 32'hF, 32'h8 | m);
      wr(OFS_CONTROL, m);
      rd_chk(OFS_CONTROL, 32'hF, 32'h4 | m);
      for (int k = 0; k < 2000 && led_drive.ir_on !== 1'b1; k++)
        @(posedge sys_clk);
      check(32'(led_drive.ir_on), 32'h1);
      check(32'(led_drive.ir_current), 32'h30);
      check(32'(led_drive.red_on), 32'h0);
      conv.send(19'h00030);
      rd_chk(OFS_CONTROL, 32'hC, 32'h4);
      rd_chk(OFS_INT_STATUS, 32'h2, 32'h0);
      conv.send(19'h7FFFF);
      rd_chk(OFS_CONTROL, 32'hC, 32'h8);
      rd_chk(OFS_INT_STATUS, 32'h2, 32'h2);
      pin_chk(1'b1);
      wr(OFS_INT_ENABLE, 32'h0);
      pin_chk(1'b0);
      wr(OFS_INT_ENABLE, 32'h2);
      pin_chk(1'b1);
      wr(OFS_INT_STATUS, 32'h2);
      pin_chk(1'b0);
      rd_chk(OFS_INT_STATUS, 32'h2, 32'h0);
    end
    // Fill past the depth, then drain in order
    wr(OFS_INT_ENABLE, 32'h0);
    wr(OFS_CONTROL, MEAS_HR);
    wr(OFS_INT_STATUS, 32'h7);
    rd_chk(OFS_FIFO_STAT, 32'h3F, 32'h0);
    for (int i = 0; i <= FIFO_DEPTH; i++)
      conv.send(smp(i));
    rd_chk(OFS_FIFO_STAT, 32'h3F, FIFO_DEPTH);
    rd_chk(OFS_INT_STATUS, 32'h7, 32'h5);
    for (int b = 0; b < INT_BITS; b++)
    begin
      wr(OFS_INT_ENABLE, 32'h1 << b);
      pin_chk(b != BIT_PRESENCE);
    end
    rd_chk(OFS_CONTROL, 32'hC, 32'h8);
    for (int i = 0; i < FIFO_DEPTH; i++)
      rd_chk(OFS_FIFO_DATA, 32'hFFFF_FFFF, {13'h0, smp(i)});
    rd_chk(OFS_FIFO_STAT, 32'h3F, 32'h0);
    // Empty read pops nothing; read pointer has wrapped back to slot 0
    rd_chk(OFS_FIFO_DATA, 32'hFFFF_FFFF, {13'h0, smp(0)});
    rd_chk(OFS_FIFO_STAT, 32'h3F, 32'h0);
    // Codes above full scale are clamped at the drive, not in the register
    wr(OFS_LED_CFG, 32'h0330_FAFF);
    rd_chk(OFS_LED_CFG, 32'hFF, 32'hFF);
    check(32'(led_drive.ir_current), 32'(CURRENT_MAX_CODE));
    check(32'(led_drive.red_current), 32'hFA);
    // Stop, then restart: the first pulse starts a conversion at once
    wr(OFS_CONTROL, MEAS_OFF);
    rd_chk(OFS_CONTROL, 32'hF, 32'h0);
    check(32'(led_drive.ir_on), 32'h0);
    wr(OFS_CONTROL, MEAS_HR);
    for (int k = 0; k < 8 && adc_start !== 1'b1; k++)
      @(posedge sys_clk);
    check(32'(adc_start), 32'h1);
    @(posedge sys_clk);
    check(32'(adc_start), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
